// [hw/dac_bringup_pkg.sv]
// Shared constants, register map and carrier types for the DAC bring-up and link check block.
package dac_bringup_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LANES  = 12;
  localparam int BANKS  = 4;
  localparam int PAT_N  = 8;

  // Register offsets (byte addresses, one word each).
  localparam logic [ADDR_W-1:0] REG_CONFIG  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ALARM   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MASK    = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_OSC     = 8'h14;
  localparam logic [ADDR_W-1:0] REG_CHKCTL  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_CHKSTAT = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_PAT0    = 8'h20;

  // CONTROL fields.
  localparam int CTL_DATAPATH_ENABLE     = 0;
  localparam int CTL_TX_A      = 1;
  localparam int CTL_TX_B      = 2;
  localparam int CTL_MRK_ALIGN = 3;
  localparam int CTL_SR_ALIGN  = 4;
  localparam int CTL_OSC_RUN   = 5;
  localparam int CTL_OSC_BLK   = 6;
  localparam int CTL_OSC_SYNC  = 7;
  localparam int CTL_SYNC_SRC  = 8;
  localparam int CTL_DLY_LSB   = 12;
  localparam int DLY_W         = 4;

  // ALARM bits, write one to clear.
  localparam int ALM_LINK_CLK = 0;
  localparam int ALM_MARKER   = 1;
  localparam int ALM_SYS      = 2;
  localparam int ALM_W        = 3;

  // STATUS bits.
  localparam int ST_FUSE_DONE = 0;
  localparam int ST_MRK_DET   = 1;
  localparam int ST_SR_DET    = 2;
  localparam int ST_FLUSHED   = 3;
  localparam int ST_MUTED     = 4;

  // Link check control bits.
  localparam int CK_EN     = 0;
  localparam int CK_CONT   = 1;
  localparam int CK_LOCK   = 2;
  localparam int CK_TRIG   = 3;
  localparam int CK_BANK   = 4;

  localparam int FUSE_WORDS  = 16;
  localparam int FLUSH_CYC   = 100;
  localparam logic [7:0] MUTE_MASK_RST = 8'h07;

  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic               clk;
    logic               marker;
    logic [LANES-1:0]   data;
  } link_pins_t;

  typedef enum logic [1:0] {
    CK_IDLE = 2'b00,
    CK_RUN  = 2'b01,
    CK_STOP = 2'b11
  } check_state_t;

endpackage

// [hw/fuse_loader.sv]
// Self-starting trim loader that walks the fuse array after reset.
`timescale 1ns/1ps
module fuse_loader #(
  parameter int WORDS = dac_bringup_pkg::FUSE_WORDS
) (
  input  wire logic clk,
  input  wire logic rstn,
  output logic      fuse_done
);
  import dac_bringup_pkg::*;

  logic [$clog2(WORDS+1)-1:0] idx_ff;

  // Loading starts on its own once reset is gone.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      idx_ff <= '0;
    else if (idx_ff != ($clog2(WORDS+1))'(WORDS))
      idx_ff <= idx_ff + 1'b1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fuse_done <= 1'b0;
    else
      fuse_done <= (idx_ff == ($clog2(WORDS+1))'(WORDS));
  end

  a_fuse_start: assert property (@(posedge clk) disable iff (!rstn)
    (idx_ff == '0) |=> (idx_ff == ($clog2(WORDS+1))'(1)))
    else $error("fuse load did not start");
  a_fuse_done_time: assert property (@(posedge clk) disable iff (!rstn)
    (idx_ff == ($clog2(WORDS+1))'(WORDS - 1)) |=> ##2 fuse_done)
    else $error("fuse done late");
endmodule

// [hw/link_sampler.sv]
// Three-stage synchroniser for the link pins with link clock edge detection.
`timescale 1ns/1ps
module link_sampler (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire dac_bringup_pkg::link_pins_t pins,
  output dac_bringup_pkg::link_pins_t      stable,
  output logic                             link_edge
);
  import dac_bringup_pkg::*;

  link_pins_t s1_ff;
  link_pins_t s2_ff;
  link_pins_t s3_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit only changes once the second and third stage agree on it.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      stable <= '0;
    else
      stable <= (s2_ff & s3_ff) | (stable & (s2_ff | s3_ff));
  end

  // Both link clock edges carry data, so either edge counts.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      link_edge <= 1'b0;
    else
      link_edge <= (s2_ff.clk == s3_ff.clk) && (s2_ff.clk != stable.clk);
  end
endmodule

// [hw/dac_bringup.sv]
// Bring-up sequencing, alignment, alarm, mute and link pattern check for the DAC.
// Function
// - Fuse load begins by itself after reset.
// - Fuse done status reads one when loaded.
// - Marker align request sets marker detected.
// - Sysref align enable sets sysref detected.
// - Wait 100 sample cycles after alarm clear.
// - Transmit via pin or channel enable bits.
// - Oscillator words apply directly while stopped.
// - Accumulator sync uses selected sync source.
// - No automatic sysref alignment in tone mode.
// - Check eight-sample pattern against expected values.
// - Stop-on-fail freezes; continue accumulates line misses.
// - Banks maskable; only configured banks checked.
// - Enable, transmit, trigger; poll running or misses.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module dac_bringup #(
  parameter int FLUSH = dac_bringup_pkg::FLUSH_CYC,
  parameter int WORDS = dac_bringup_pkg::FUSE_WORDS
) (
  input  wire logic                                   clk,
  input  wire logic                                   rstn,
  input  wire dac_bringup_pkg::reg_req_t              req,
  output logic [dac_bringup_pkg::DATA_W-1:0]          rdata_ff,
  input  wire dac_bringup_pkg::link_pins_t            link_pins,
  input  wire logic                                   sysref,
  input  wire logic                                   tx_pin,
  input  wire logic                                   sync_request_low,
  output logic                                        out_mute_ff,
  output logic [1:0]                                  tx_active_ff,
  output logic [31:0]                                 osc_freq_ff,
  output logic                                        osc_sync_ff
);
  import dac_bringup_pkg::*;

  logic        fuse_done;
  link_pins_t  lnk;
  logic        link_edge;
  logic [31:0] config_ff;
  logic [31:0] control_ff;
  logic [ALM_W-1:0] alarm_ff;
  logic [7:0]  mute_mask_ff;
  logic        mrk_det_ff;
  logic        sr_det_ff;
  logic [31:0] osc_shadow_ff;
  logic [7:0]  chkctl_ff;
  logic [LANES-1:0] pat_ff [PAT_N];
  logic [7:0]  flush_cnt_ff;
  logic        flushed_ff;
  logic [2:0]  pos_ff;
  logic [LANES-1:0] miss_ff;
  logic [LANES-1:0] fail_frame_ff;
  logic [2:0]  fail_pos_ff;
  logic        fail_sum_ff;
  check_state_t ck_ff;
  logic [2:0]  sr_hist_ff;
  logic        sr_edge;
  logic [LANES-1:0] bank_lanes;
  logic [LANES-1:0] diff;
  logic        wr_ctl;
  logic        sys_clear;

  fuse_loader #(.WORDS(WORDS)) u_fuse (
    .clk       (clk),
    .rstn      (rstn),
    .fuse_done (fuse_done)
  );

  link_sampler u_link (
    .clk       (clk),
    .rstn      (rstn),
    .pins      (link_pins),
    .stable    (lnk),
    .link_edge (link_edge)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register writes.

  assign wr_ctl    = req.wr && (req.addr == REG_CONTROL);
  assign sys_clear = req.wr && (req.addr == REG_ALARM) && req.wdata[ALM_SYS];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      config_ff    <= '0;
      control_ff   <= '0;
      mute_mask_ff <= MUTE_MASK_RST;
      chkctl_ff    <= '0;
    end
    else
    begin
      if (req.wr && req.addr == REG_CONFIG)
        config_ff <= req.wdata;
      if (wr_ctl)
        control_ff <= req.wdata;
      else
        control_ff[CTL_OSC_SYNC] <= 1'b0;
      if (req.wr && req.addr == REG_MASK)
        mute_mask_ff <= req.wdata[7:0];
      if (req.wr && req.addr == REG_CHKCTL)
        chkctl_ff <= req.wdata[7:0];
      else
        chkctl_ff[CK_TRIG] <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PAT_N; g++)
    begin : g_pat
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          pat_ff[g] <= '0;
        else if (req.wr && req.addr == REG_PAT0 + ADDR_W'(4 * g))
          pat_ff[g] <= req.wdata[LANES-1:0];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator: words apply directly while stopped, else only when not blocked.

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_shadow_ff <= '0;
      osc_freq_ff   <= '0;
    end
    else
    begin
      if (req.wr && req.addr == REG_OSC)
        osc_shadow_ff <= req.wdata;
      if (!control_ff[CTL_OSC_RUN] || !control_ff[CTL_OSC_BLK])
        osc_freq_ff <= osc_shadow_ff;
    end
  end

  // Sync source 0 is the software pulse, 1 is a captured sysref edge.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      osc_sync_ff <= 1'b0;
    else
      osc_sync_ff <= control_ff[CTL_OSC_RUN] &&
                     (control_ff[CTL_SYNC_SRC] ? sr_edge : control_ff[CTL_OSC_SYNC]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alignment and alarms.

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sr_hist_ff <= '0;
    else
      sr_hist_ff <= {sr_hist_ff[1:0], sysref};
  end
  assign sr_edge = sr_hist_ff[1] && sr_hist_ff[2] == sr_hist_ff[1] ? 1'b0 : sr_hist_ff[1];

  // Detection flags: any write to status clears; a capture in the same cycle wins.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mrk_det_ff <= 1'b0;
      sr_det_ff  <= 1'b0;
    end
    else
    begin
      if (control_ff[CTL_DATAPATH_ENABLE] && control_ff[CTL_MRK_ALIGN] && lnk.marker && link_edge)
        mrk_det_ff <= 1'b1;
      else if (req.wr && req.addr == REG_STATUS)
        mrk_det_ff <= 1'b0;
      // Sysref never aligns on its own; the enable must be set.
      if (control_ff[CTL_DATAPATH_ENABLE] && control_ff[CTL_SR_ALIGN] && sr_edge)
        sr_det_ff <= 1'b1;
      else if (req.wr && req.addr == REG_STATUS)
        sr_det_ff <= 1'b0;
    end
  end

  // Alarms: link clock stall, marker out of period; write one clears, set wins.
  logic [3:0] idle_ff;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      idle_ff <= '0;
    else if (link_edge || !control_ff[CTL_DATAPATH_ENABLE])
      idle_ff <= '0;
    else if (idle_ff != 4'hF)
      idle_ff <= idle_ff + 4'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      alarm_ff <= '0;
    else
    begin
      logic [ALM_W-1:0] set;
      set = '0;
      set[ALM_LINK_CLK] = (idle_ff == 4'hE);
      set[ALM_MARKER]   = control_ff[CTL_DATAPATH_ENABLE] && link_edge && lnk.marker && (pos_ff != 3'h0);
      set[ALM_SYS]      = set[ALM_LINK_CLK] | set[ALM_MARKER];
      alarm_ff <= (alarm_ff & ~((req.wr && req.addr == REG_ALARM) ?
                   req.wdata[ALM_W-1:0] : '0)) | set;
    end
  end

  // Flush counter restarts on every system alarm clear.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flush_cnt_ff <= '0;
      flushed_ff   <= 1'b0;
    end
    else if (sys_clear)
    begin
      flush_cnt_ff <= '0;
      flushed_ff   <= 1'b0;
    end
    else if (flush_cnt_ff != 8'(FLUSH))
      flush_cnt_ff <= flush_cnt_ff + 8'h1;
    else
      flushed_ff <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit and mute.

  logic [1:0] tx_req;
  assign tx_req = {control_ff[CTL_TX_B], control_ff[CTL_TX_A]} | {2{tx_pin}};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tx_active_ff <= '0;
    else
      tx_active_ff <= tx_req & {2{control_ff[CTL_DATAPATH_ENABLE] && flushed_ff}};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      out_mute_ff <= 1'b1;
    else
      out_mute_ff <= (tx_req == 2'b00) || !flushed_ff ||
                     (alarm_ff[ALM_LINK_CLK] && !mute_mask_ff[6]) ||
                     (alarm_ff[ALM_MARKER] && !mute_mask_ff[5]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link pattern check.

  generate
    for (g = 0; g < BANKS; g++)
    begin : g_bank
      // Bank used when enabled by channel setting and not masked.
      assign bank_lanes[g*3 +: 3] = {3{config_ff[g] && !chkctl_ff[CK_BANK+g]}};
    end
  endgenerate

  assign diff = (lnk.data ^ pat_ff[pos_ff]) & bank_lanes;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pos_ff <= '0;
    // A marker sample is position zero, so the sample after it is position one.
    else if (link_edge && lnk.marker && (chkctl_ff[CK_LOCK] || control_ff[CTL_MRK_ALIGN]))
      pos_ff <= 3'h1;
    else if (link_edge)
      pos_ff <= pos_ff + 3'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ck_ff         <= CK_IDLE;
      miss_ff       <= '0;
      fail_frame_ff <= '0;
      fail_pos_ff   <= '0;
      fail_sum_ff   <= 1'b0;
    end
    else
    begin
      unique case (ck_ff)
        CK_IDLE:
          if (chkctl_ff[CK_EN] && chkctl_ff[CK_TRIG] && tx_req != 2'b00)
          begin
            ck_ff       <= CK_RUN;
            miss_ff     <= '0;
            fail_sum_ff <= 1'b0;
          end
        CK_RUN:
          if (!chkctl_ff[CK_EN])
            ck_ff <= CK_IDLE;
          else if (link_edge && diff != '0)
          begin
            miss_ff     <= miss_ff | diff;
            fail_sum_ff <= 1'b1;
            if (!chkctl_ff[CK_CONT])
            begin
              fail_frame_ff <= lnk.data;
              fail_pos_ff   <= pos_ff;
              ck_ff         <= CK_STOP;
            end
          end
        CK_STOP:
          if (!chkctl_ff[CK_EN])
            ck_ff <= CK_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after the strobe.

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= '0;
    else if (req.rd)
      unique case (req.addr)
        REG_CONFIG:  rdata_ff <= config_ff;
        REG_CONTROL: rdata_ff <= control_ff;
        REG_ALARM:   rdata_ff <= {29'h0, alarm_ff};
        REG_MASK:    rdata_ff <= {24'h0, mute_mask_ff};
        REG_STATUS:  rdata_ff <= {27'h0, out_mute_ff, flushed_ff, sr_det_ff,
                                  mrk_det_ff, fuse_done};
        REG_OSC:     rdata_ff <= osc_shadow_ff;
        REG_CHKCTL:  rdata_ff <= {22'h0, fail_sum_ff, ck_ff == CK_RUN, chkctl_ff};
        REG_CHKSTAT: rdata_ff <= {5'h0, fail_pos_ff, fail_frame_ff, miss_ff};
        default:     rdata_ff <= '0;
      endcase
    else
      rdata_ff <= '0;
  end

  a_tx_needs_flush: assert property (@(posedge clk) disable iff (!rstn)
    sys_clear |=> ##1 (tx_active_ff == 2'b00))
    else $error("transmit before flush");
  a_mute_no_tx: assert property (@(posedge clk) disable iff (!rstn)
    (tx_req == 2'b00) |=> out_mute_ff)
    else $error("output unmuted without transmit");
  a_tx_pin: assert property (@(posedge clk) disable iff (!rstn)
    (tx_pin && control_ff[CTL_DATAPATH_ENABLE] && flushed_ff) |=> (tx_active_ff == 2'b11))
    else $error("pin did not enable transmit");
  a_osc_direct: assert property (@(posedge clk) disable iff (!rstn)
    !control_ff[CTL_OSC_RUN] |=> (osc_freq_ff == $past(osc_shadow_ff)))
    else $error("oscillator word not applied");
  a_mrk_detect: assert property (@(posedge clk) disable iff (!rstn)
    (control_ff[CTL_DATAPATH_ENABLE] && control_ff[CTL_MRK_ALIGN] && lnk.marker && link_edge)
    |=> mrk_det_ff)
    else $error("marker not detected");
  a_sr_needs_en: assert property (@(posedge clk) disable iff (!rstn)
    (!sr_det_ff && !control_ff[CTL_SR_ALIGN]) |=> !sr_det_ff)
    else $error("sysref aligned without enable");
  a_stop_freeze: assert property (@(posedge clk) disable iff (!rstn)
    (ck_ff == CK_STOP && chkctl_ff[CK_EN]) |=> $stable(fail_frame_ff) && ck_ff == CK_STOP)
    else $error("stopped check changed");
  a_bank_mask: assert property (@(posedge clk) disable iff (!rstn)
    ((diff & ~bank_lanes) == '0))
    else $error("masked bank checked");
  a_sync_src: assert property (@(posedge clk) disable iff (!rstn)
    osc_sync_ff |-> $past(control_ff[CTL_OSC_RUN]))
    else $error("sync while stopped");
endmodule

// [verification/link_source.sv]
// Far-side model: a source that drives the link clock, frame marker and pattern samples.
`timescale 1ns/1ps
module link_source #(
  parameter realtime HALF = 400.0
) (
  input  wire logic                  run,
  input  wire logic [11:0]           flip,
  output dac_bringup_pkg::link_pins_t pins,
  output logic                       sync_request_low
);
  import dac_bringup_pkg::*;
  logic [2:0] idx;

  // Data moves a quarter period ahead of each clock edge, so every edge is centred.
  // The clock stands still whenever the source is not running.
  initial
  begin
    idx = 3'h0;
    pins = '0;
    sync_request_low = 1'b0;
    forever
    begin
      wait (run);
      #(HALF / 2);
      pins.data = (12'h0F0 ^ (idx * 12'h123)) ^ flip;
      pins.marker = (idx == 3'h0);
      #(HALF / 2);
      pins.clk = ~pins.clk;
      idx = idx + 3'h1;
    end
  end
endmodule

// [verification/dac_bringup_tb.sv]
// Self-checking bench for bring-up sequencing, transmit gating and the link pattern check.
`timescale 1ns/1ps
module dac_bringup_tb;
  import dac_bringup_pkg::*;
  localparam int FLUSH_SIM = 10;
  localparam logic [31:0] DP  = 32'h1 << CTL_DATAPATH_ENABLE;
  localparam logic [31:0] CKE = 32'h1 << CK_EN;
  localparam logic [31:0] CKT = 32'h1 << CK_TRIG;
  localparam logic [31:0] CKC = 32'h1 << CK_CONT;

  logic             clk;
  logic             rstn;
  reg_req_t         req;
  logic [31:0]      rdata_ff;
  link_pins_t       link_pins;
  logic             sysref;
  logic             tx_pin;
  logic             sync_request_low;
  logic             out_mute_ff;
  logic [1:0]       tx_active_ff;
  logic [31:0]      osc_freq_ff;
  logic             osc_sync_ff;
  logic             run;
  logic [11:0]      flip;
  logic             sync_seen;
  logic [31:0]      d;
  int               err_total;
  int               total_checks;

  dac_bringup #(.FLUSH(FLUSH_SIM), .WORDS(4)) dac_bringup_i (
    .clk(clk), .rstn(rstn), .req(req), .rdata_ff(rdata_ff), .link_pins(link_pins),
    .sysref(sysref), .tx_pin(tx_pin), .sync_request_low(sync_request_low),
    .out_mute_ff(out_mute_ff), .tx_active_ff(tx_active_ff), .osc_freq_ff(osc_freq_ff),
    .osc_sync_ff(osc_sync_ff));

  link_source link_source_i (.run(run), .flip(flip), .pins(link_pins),
    .sync_request_low(sync_request_low));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
    if (osc_sync_ff === 1'b1)
      sync_seen <= 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata_ff;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Polls a status bit under a bounded count, then compares what was last read.
  task automatic poll(input string n, input logic [ADDR_W-1:0] a, input int b);
    for (int k = 0; k < 200; k++)
    begin
      rd(a);
      if (d[b] === 1'b1)
        break;
    end
    chk(n, 32'h1, {31'h0, d[b]});
  endtask

  task automatic sysref_pulse();
    @(posedge clk);
    sysref <= 1'b1;
    repeat (4) @(posedge clk);
    sysref <= 1'b0;
  endtask

  function automatic logic [11:0] pat(input logic [2:0] k);
    return 12'h0F0 ^ (k * 12'h123);
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #3000000;
    err_total++;
    end_of_test();
  end

  initial
  begin
    err_total = 0;
    total_checks = 0;
    rstn = 1'b0;
    req = '0;
    sysref = 1'b0;
    tx_pin = 1'b0;
    run = 1'b0;
    flip = 12'h000;
    sync_seen = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    run <= 1'b1;
    chk("mute_reset", 32'h1, {31'h0, out_mute_ff});
    chk("tx_reset", 32'h0, {30'h0, tx_active_ff});
    poll("fuse_done", REG_STATUS, ST_FUSE_DONE);
    rd(REG_MASK);
    chk("mute_mask_reset", {24'h0, MUTE_MASK_RST}, d);
    rd(8'hFC);
    chk("unmapped_read", 32'h0, d);
    $display("test reset done");

    wr(REG_CONFIG, 32'h1);
    wr(REG_CONTROL, DP);
    wr(REG_ALARM, 32'h3);
    wr(REG_CONTROL, DP | (32'h1 << CTL_MRK_ALIGN));
    poll("marker_detected", REG_STATUS, ST_MRK_DET);
    wr(REG_CONTROL, DP);
    wr(REG_STATUS, 32'h0);
    rd(REG_STATUS);
    chk("marker_det_cleared", 32'h0, {31'h0, d[ST_MRK_DET]});
    wr(REG_CONTROL, DP | (32'h1 << CTL_SR_ALIGN));
    sysref_pulse();
    poll("sysref_detected", REG_STATUS, ST_SR_DET);
    wr(REG_CONTROL, DP | (32'h1 << CTL_TX_A) | (32'h3 << CTL_DLY_LSB));
    wr(REG_ALARM, 32'h7);
    rd(REG_STATUS);
    chk("flushed_early", 32'h0, {31'h0, d[ST_FLUSHED]});
    chk("tx_before_flush", 32'h0, {30'h0, tx_active_ff});
    repeat (FLUSH_SIM) @(posedge clk);
    rd(REG_STATUS);
    chk("flushed", 32'h1, {31'h0, d[ST_FLUSHED]});
    chk("tx_register", 32'h1, {30'h0, tx_active_ff});
    chk("unmuted", 32'h0, {31'h0, out_mute_ff});
    wr(REG_CONTROL, DP);
    repeat (3) @(posedge clk);
    chk("tx_off", 32'h0, {30'h0, tx_active_ff});
    chk("muted_again", 32'h1, {31'h0, out_mute_ff});
    tx_pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk("tx_pin", 32'h3, {30'h0, tx_active_ff});
    tx_pin <= 1'b0;
    $display("test startup done");

    wr(REG_OSC, 32'h1234_5678);
    repeat (3) @(posedge clk);
    chk("osc_word_direct", 32'h1234_5678, osc_freq_ff);
    sync_seen <= 1'b0;
    wr(REG_CONTROL, DP | (32'h1 << CTL_OSC_RUN) | (32'h1 << CTL_OSC_SYNC));
    repeat (3) @(posedge clk);
    chk("osc_sync_soft", 32'h1, {31'h0, sync_seen});
    sync_seen <= 1'b0;
    wr(REG_CONTROL, DP | (32'h1 << CTL_OSC_RUN) | (32'h1 << CTL_SYNC_SRC));
    repeat (3) @(posedge clk);
    chk("osc_sync_idle", 32'h0, {31'h0, sync_seen});
    sysref_pulse();
    repeat (20) @(posedge clk);
    chk("osc_sync", 32'h1, {31'h0, sync_seen});
    $display("test oscillator done");

    for (int i = 0; i < PAT_N; i++)
      wr(REG_PAT0 + 8'(4 * i), {20'h0, pat(3'(i))});
    wr(REG_CONTROL, DP | (32'h1 << CTL_TX_A));
    wr(REG_CHKCTL, CKE);
    wr(REG_CHKCTL, CKE | CKT);
    repeat (100) @(posedge clk);
    rd(REG_CHKCTL);
    chk("check_clean", 32'h100, d & 32'h300);
    flip <= 12'h001;
    repeat (100) @(posedge clk);
    rd(REG_CHKCTL);
    chk("check_stopped", 32'h200, d & 32'h300);
    rd(REG_CHKSTAT);
    chk("fail_frame", {20'h0, pat(d[26:24]) ^ 12'h001}, {20'h0, d[23:12]});
    wr(REG_CHKCTL, 32'h0);
    flip <= 12'h004;
    wr(REG_CHKCTL, CKE | CKC);
    wr(REG_CHKCTL, CKE | CKC | CKT);
    repeat (100) @(posedge clk);
    rd(REG_CHKSTAT);
    chk("line_misses", 32'h004, {20'h0, d[11:0]});
    rd(REG_CHKCTL);
    chk("continue_running", 32'h300, d & 32'h300);
    wr(REG_CHKCTL, 32'h0);
    wr(REG_CHKCTL, CKE | CKC | (32'hF << CK_BANK));
    wr(REG_CHKCTL, CKE | CKC | (32'hF << CK_BANK) | CKT);
    repeat (100) @(posedge clk);
    rd(REG_CHKSTAT);
    chk("masked_misses", 32'h0, {20'h0, d[11:0]});
    rd(REG_CHKCTL);
    chk("masked_summary", 32'h100, d & 32'h300);
    $display("test link check done");
    end_of_test();
  end
endmodule
